// file: logic/port_status_pkg.sv
/*
 * port_status_pkg: register offset, bit positions and timing counts for the
 * root hub downstream port status and control word.
 * assumes: a 100 MHz system clock.
 */
package port_status_pkg;

	// ==========================================================
	// register map
	localparam logic [7:0] PORT_STATUS_CONTROL_OFFSET = 8'h54;

	// ==========================================================
	// bit positions inside the word
	localparam int BIT_ATTACHED  = 0;
	localparam int BIT_ENABLE    = 1;
	localparam int BIT_SUSPEND   = 2;
	localparam int BIT_OVERCUR   = 3;
	localparam int BIT_RESET     = 4;
	localparam int BIT_CONN_CHG  = 16;
	localparam int BIT_EN_CHG    = 17;
	localparam int BIT_SUSP_CHG  = 18;
	localparam int BIT_OC_CHG    = 19;
	localparam int BIT_RST_CHG   = 20;

	// ==========================================================
	// timing, clock at 100 MHz
	localparam int CLK_PERIOD_NS   = 10;
	localparam int RESET_TIME_US   = 10;
	localparam int RESUME_TIME_US  = 20;
	localparam int RESET_CYCLES    = (RESET_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int RESUME_CYCLES   = (RESUME_TIME_US * 1000) / CLK_PERIOD_NS;
	localparam int TIMER_W         = 12;

	// ==========================================================
	// port sequencer states
	typedef enum logic [1:0] {
		SEQ_IDLE,
		SEQ_RESET,
		SEQ_RESUME
	} seq_state_e;

endpackage

// file: logic/port_timer.sv
/*
 * port_timer: down counter that times the port reset and resume intervals.
 * assumes: start is a one-cycle pulse; load value is nonzero.
 */
`timescale 1ns/1ps
module port_timer
	import port_status_pkg::*;
(
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               rst_n,
	// control
	input  wire logic               start,
	input  wire logic [TIMER_W-1:0] load,
	// result
	output logic                    done_q
);

	logic [TIMER_W-1:0] count_q;
	logic               busy_q;

	// ==========================================================
	// counter: reload on start, pulse done on reaching one
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			count_q <= '0;
			busy_q  <= 1'b0;
			done_q  <= 1'b0;
		end else begin
			done_q <= 1'b0;
			if (start) begin
				count_q <= load;
				busy_q  <= 1'b1;
			end else if (busy_q) begin
				if (count_q == TIMER_W'(1)) begin
					busy_q <= 1'b0;
					done_q <= 1'b1;
				end
				count_q <= count_q - TIMER_W'(1);
			end
		end
	end

endmodule

// file: logic/root_hub_port_status_ctrl.sv
/*
 * root_hub_port_status_ctrl: status and control bits of one root hub
 * downstream port, with write-one commands and the reset and resume sequencer.
 * assumes: the register port below is a simple word strobe from the host
 * controller decode; connect, overcurrent and error events come from the
 * port logic, synchronous to sys_clk.
 * limitation: reset or resume writes while a sequence runs are dropped.
 * a write that asks for both reset and resume is taken as a reset.
 * change bits 16..20 clear by writing one; a set in the same cycle wins.
 */
// Summary of operation
// - write one bit4 starts reset, status reads one
// - reset end sets change, clears reset status
// - reset write while detached sets connect change
// - bit3 shows overcurrent only when per-port
// - write one bit3 resumes only when suspended
// - suspend set by write, cleared at resume end
// - suspend write while detached sets connect change
// - suspend cleared at reset end, hc resume
// - downstream resume of suspended port reaches controller
// - hub clears enable on faults, sets change
// - enable by commands, never while detached
// - enable set at reset or resume end
// - bit0 reads attach, one when nonremovable
// - enable write while detached sets connect change
`timescale 1ns/1ps
module root_hub_port_status_ctrl
	import port_status_pkg::*;
(
	// clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst_n,
	// register access
	input  wire logic [7:0]  reg_addr,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [31:0] reg_wdata,
	output logic [31:0]      reg_rdata_q,
	// port side events
	input  wire logic        device_present,
	input  wire logic        device_nonremovable,
	input  wire logic        overcurrent_in,
	input  wire logic        per_port_overcurrent,
	input  wire logic        port_power_lost,
	input  wire logic        bus_error,
	input  wire logic        downstream_resume,
	input  wire logic        hc_resume_state,
	// port drive and controller notification
	output logic             port_reset_drive_q,
	output logic             port_resume_drive_q,
	output logic             resume_to_hc_q
);

	// status bits
	logic       port_reset_active_q;
	logic       port_suspended_q;
	logic       port_enabled_q;
	logic       reset_done_change_q;
	logic       suspend_change_flag_q;
	logic       connect_change_flag_q;
	logic       enable_change_q;
	logic       overcur_change_q;
	logic       attached_prev_q;
	seq_state_e seq_q;

	// decoded strobes and derived levels
	logic        hit_wr;
	logic        cmd_clr_enable;
	logic        cmd_set_enable;
	logic        cmd_set_suspend;
	logic        cmd_resume;
	logic        cmd_set_reset;
	logic        device_attached;
	logic        port_overcurrent_flag;
	logic        reset_done;
	logic        resume_done;
	logic        timer_start;
	logic        timer_done;
	logic        hw_disable;
	logic        detach_event;
	logic [TIMER_W-1:0] timer_load;
	logic [31:0] status_word;

	// change events and write-one clears, bit 16 upwards
	logic [4:0]  change_set;
	logic [4:0]  change_clr;

	// ==========================================================
	// command decode: each bit only a write-one strobe
	assign hit_wr          = reg_wr && (reg_addr == PORT_STATUS_CONTROL_OFFSET);
	assign cmd_clr_enable  = hit_wr && reg_wdata[BIT_ATTACHED];
	assign cmd_set_enable  = hit_wr && reg_wdata[BIT_ENABLE];
	assign cmd_set_suspend = hit_wr && reg_wdata[BIT_SUSPEND];
	assign cmd_resume      = hit_wr && reg_wdata[BIT_OVERCUR];
	assign cmd_set_reset   = hit_wr && reg_wdata[BIT_RESET];

	// ==========================================================
	// live status levels
	assign device_attached       = device_present || device_nonremovable;
	assign port_overcurrent_flag = per_port_overcurrent && overcurrent_in;
	assign detach_event          = attached_prev_q && !device_attached;
	assign hw_disable            = overcurrent_in || detach_event || port_power_lost || bus_error;

	// ==========================================================
	// sequencer timer
	// a new interval starts only from idle on an attached port
	assign timer_start = (seq_q == SEQ_IDLE) && device_attached
		&& (cmd_set_reset || (cmd_resume && port_suspended_q));
	assign timer_load  = cmd_set_reset ? TIMER_W'(RESET_CYCLES) : TIMER_W'(RESUME_CYCLES);
	assign reset_done  = timer_done && (seq_q == SEQ_RESET);
	assign resume_done = timer_done && (seq_q == SEQ_RESUME);

	// one down counter times both intervals
	port_timer u_timer (
		.sys_clk (sys_clk),
		.rst_n   (rst_n),
		.start   (timer_start),
		.load    (timer_load),
		.done_q  (timer_done)
	);

	// ==========================================================
	// sequencer: reset has priority over resume
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			seq_q <= SEQ_IDLE;
		end else begin
			unique case (seq_q)
				SEQ_IDLE: begin
					if (timer_start && cmd_set_reset) begin
						seq_q <= SEQ_RESET;
					end else if (timer_start) begin
						seq_q <= SEQ_RESUME;
					end
				end
				SEQ_RESET: begin
					if (timer_done) begin
						seq_q <= SEQ_IDLE;
					end
				end
				SEQ_RESUME: begin
					if (timer_done) begin
						seq_q <= SEQ_IDLE;
					end
				end
				default: seq_q <= SEQ_IDLE;
			endcase
		end
	end

	// ==========================================================
	// port reset status
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			port_reset_active_q <= 1'b0;
		end else if (timer_start && cmd_set_reset) begin
			port_reset_active_q <= 1'b1;
		end else if (reset_done) begin
			port_reset_active_q <= 1'b0;
		end
	end

	// ==========================================================
	// suspend status: set by command, cleared at resume end
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			port_suspended_q <= 1'b0;
		end else if (resume_done || reset_done || hc_resume_state) begin
			port_suspended_q <= 1'b0;
		end else if (cmd_set_suspend && device_attached) begin
			port_suspended_q <= 1'b1;
		end
	end

	// ==========================================================
	// enable status
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			port_enabled_q <= 1'b0;
		end else if (!device_attached) begin
			port_enabled_q <= 1'b0;
		end else if (hw_disable || cmd_clr_enable) begin
			port_enabled_q <= 1'b0;
		end else if (cmd_set_enable || reset_done || resume_done) begin
			port_enabled_q <= 1'b1;
		end
	end

	// ==========================================================
	// attach history for the connect and detach edges
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			attached_prev_q <= 1'b0;
		end else begin
			attached_prev_q <= device_attached;
		end
	end

	// ==========================================================
	// change events, index 0 is bit 16 of the word
	assign change_set[0] = (!device_attached && (cmd_set_reset || cmd_set_suspend || cmd_set_enable))
		|| (attached_prev_q != device_attached);
	assign change_set[1] = port_enabled_q && (hw_disable || !device_attached);
	assign change_set[2] = resume_done;
	assign change_set[3] = port_overcurrent_flag;
	assign change_set[4] = reset_done;

	// write-one clears, one per change bit
	for (genvar i = 0; i <= BIT_RST_CHG - BIT_CONN_CHG; i++) begin : g_change_clr
		assign change_clr[i] = hit_wr && reg_wdata[BIT_CONN_CHG + i];
	end

	// ==========================================================
	// change flags: set wins over a write-one clear at bits 16..20
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reset_done_change_q   <= 1'b0;
			suspend_change_flag_q <= 1'b0;
			connect_change_flag_q <= 1'b0;
			enable_change_q       <= 1'b0;
			overcur_change_q      <= 1'b0;
		end else begin
			if (change_set[4]) begin
				reset_done_change_q <= 1'b1;
			end else if (change_clr[4]) begin
				reset_done_change_q <= 1'b0;
			end
			if (change_set[2]) begin
				suspend_change_flag_q <= 1'b1;
			end else if (change_clr[2]) begin
				suspend_change_flag_q <= 1'b0;
			end
			if (change_set[0]) begin
				connect_change_flag_q <= 1'b1;
			end else if (change_clr[0]) begin
				connect_change_flag_q <= 1'b0;
			end
			if (change_set[1]) begin
				enable_change_q <= 1'b1;
			end else if (change_clr[1]) begin
				enable_change_q <= 1'b0;
			end
			if (change_set[3]) begin
				overcur_change_q <= 1'b1;
			end else if (change_clr[3]) begin
				overcur_change_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// port drive, dropped in the cycle the timer ends
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			port_reset_drive_q  <= 1'b0;
			port_resume_drive_q <= 1'b0;
		end else begin
			port_reset_drive_q  <= (seq_q == SEQ_RESET) && !timer_done;
			port_resume_drive_q <= (seq_q == SEQ_RESUME) && !timer_done;
		end
	end

	// ==========================================================
	// upstream resume notification from a suspended port
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			resume_to_hc_q <= 1'b0;
		end else begin
			resume_to_hc_q      <= downstream_resume && port_suspended_q;
		end
	end

	// ==========================================================
	// read view: status only, other bits zero
	always_comb begin
		status_word               = '0;
		status_word[BIT_ATTACHED] = device_attached;
		status_word[BIT_ENABLE]   = port_enabled_q;
		status_word[BIT_SUSPEND]  = port_suspended_q;
		status_word[BIT_OVERCUR]  = port_overcurrent_flag;
		status_word[BIT_RESET]    = port_reset_active_q;
		status_word[BIT_CONN_CHG] = connect_change_flag_q;
		status_word[BIT_EN_CHG]   = enable_change_q;
		status_word[BIT_SUSP_CHG] = suspend_change_flag_q;
		status_word[BIT_OC_CHG]   = overcur_change_q;
		status_word[BIT_RST_CHG]  = reset_done_change_q;
	end

	// ==========================================================
	// registered read data, zero for other addresses
	always_ff @(posedge sys_clk) begin
		if (!rst_n) begin
			reg_rdata_q <= '0;
		end else if (reg_rd && (reg_addr == PORT_STATUS_CONTROL_OFFSET)) begin
			reg_rdata_q <= status_word;
		end else begin
			reg_rdata_q <= '0;
		end
	end

endmodule

// file: verif/usb_dev_model.sv
/*
 * usb_dev_model: downstream device on the root hub port.
 * assumes: bench sets attach and wake off the rising edge.
 */
`timescale 1ns/1ps
module usb_dev_model (
	// clock and bench control
	input  wire logic sys_clk,
	input  wire logic attach,
	input  wire logic wake,
	// port side
	input  wire logic port_reset_drive_q,
	output logic      device_present,
	output logic      downstream_resume
);
	// ==========================================================
	// connect level and remote wake signalling, quiet under port reset
	assign device_present = attach;
	always_ff @(posedge sys_clk) begin
		downstream_resume <= wake && attach && !port_reset_drive_q;
	end
endmodule

// file: verif/port_status_chk.sv
/*
 * port_status_chk: timing and read view checks of the port status word.
 * assumes: bound to root_hub_port_status_ctrl, one clock domain.
 */
`timescale 1ns/1ps
module port_status_chk
	import port_status_pkg::*;
(
	// clock and reset
	input wire logic        sys_clk,
	input wire logic        rst_n,
	// register access
	input wire logic [7:0]  reg_addr,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata_q,
	// port side
	input wire logic        device_present,
	input wire logic        device_nonremovable,
	input wire logic        per_port_overcurrent,
	input wire logic        downstream_resume,
	input wire logic        port_reset_drive_q,
	input wire logic        port_resume_drive_q,
	input wire logic        resume_to_hc_q
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);
	// ==========================================================
	// length of each drive interval
	logic [11:0] rst_len_q;
	logic [11:0] res_len_q;
	always_ff @(posedge sys_clk) begin
		rst_len_q <= (!rst_n || !port_reset_drive_q) ? 12'h000 : rst_len_q + 12'h001;
	end
	always_ff @(posedge sys_clk) begin
		res_len_q <= (!rst_n || !port_resume_drive_q) ? 12'h000 : res_len_q + 12'h001;
	end
	// ==========================================================
	// command and read sequences
	sequence s_rst_cmd;
		reg_wr && reg_addr == PORT_STATUS_CONTROL_OFFSET && reg_wdata[BIT_RESET] && !port_reset_drive_q
			&& !port_resume_drive_q;
	endsequence
	sequence s_rd_hit;
		reg_rd && reg_addr == PORT_STATUS_CONTROL_OFFSET;
	endsequence
	a_reset_starts: assert property (s_rst_cmd ##0 device_present |-> ##[1:3] port_reset_drive_q)
		else $error("reset drive did not start");
	a_reset_detached: assert property (s_rst_cmd ##0 !device_present && !device_nonremovable
		|-> ##1 !port_reset_drive_q [*3]) else $error("reset driven on a detached port");
	a_reset_length: assert property ($fell(port_reset_drive_q) |->
		rst_len_q inside {[RESET_CYCLES-4:RESET_CYCLES+4]}) else $error("reset drive length wrong");
	a_resume_length: assert property ($fell(port_resume_drive_q) |->
		res_len_q inside {[RESUME_CYCLES-4:RESUME_CYCLES+4]}) else $error("resume drive length wrong");
	a_one_drive: assert property (!(port_reset_drive_q && port_resume_drive_q))
		else $error("reset and resume driven together");
	a_wake_cause: assert property ($rose(resume_to_hc_q) |-> $past(downstream_resume))
		else $error("resume passed on without cause");
	a_oc_hidden: assert property (s_rd_hit ##0 !per_port_overcurrent |=> !reg_rdata_q[BIT_OVERCUR])
		else $error("overcurrent shown without per port reporting");
	a_attach_fixed: assert property (s_rd_hit ##0 device_nonremovable |=> reg_rdata_q[BIT_ATTACHED])
		else $error("fixed device not shown attached");
	a_miss_zero: assert property (reg_rd && reg_addr != PORT_STATUS_CONTROL_OFFSET |=> reg_rdata_q == 32'h0)
		else $error("unmapped read not zero");
endmodule
bind root_hub_port_status_ctrl port_status_chk chk (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
	.device_present(device_present), .device_nonremovable(device_nonremovable),
	.per_port_overcurrent(per_port_overcurrent), .downstream_resume(downstream_resume),
	.port_reset_drive_q(port_reset_drive_q), .port_resume_drive_q(port_resume_drive_q),
	.resume_to_hc_q(resume_to_hc_q));

// file: verif/testbench.sv
/*
 * testbench: scenario tasks for the port status word.
 * assumes: inputs change at the falling edge; checker bound separately.
 */
`timescale 1ns/1ps
module testbench;
	import port_status_pkg::*;
	logic        sys_clk, rst_n, reg_wr, reg_rd, nonrem, oc, ppo, pwr, berr, hcres, attach, wake;
	logic        present, dres, rdrv, mdrv, tohc;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata, reg_rdata_q;
	int          num_errors, n_compared;
	root_hub_port_status_ctrl dut (.sys_clk(sys_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q), .device_present(present),
		.device_nonremovable(nonrem), .overcurrent_in(oc), .per_port_overcurrent(ppo), .port_power_lost(pwr),
		.bus_error(berr), .downstream_resume(dres), .hc_resume_state(hcres), .port_reset_drive_q(rdrv),
		.port_resume_drive_q(mdrv), .resume_to_hc_q(tohc));
	usb_dev_model dev (.sys_clk(sys_clk), .attach(attach), .wake(wake), .port_reset_drive_q(rdrv),
		.device_present(present), .downstream_resume(dres));
	// ==========================================================
	// bus cycles and compare
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input logic [31:0] m);
		n_compared++;
		if ((got & m) !== (exp & m)) begin
			num_errors++;
			$display("BAD %0t: got %h want %h mask %h", $time, got, exp, m);
		end
	endtask
	task automatic wr(input logic [31:0] d, input logic [7:0] a = PORT_STATUS_CONTROL_OFFSET);
		@(negedge sys_clk) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
		@(negedge sys_clk) reg_wr = 1'b0;
	endtask
	task automatic rd(input logic [31:0] e, input logic [31:0] m, input logic [7:0] a = PORT_STATUS_CONTROL_OFFSET);
		@(negedge sys_clk) {reg_addr, reg_rd} = {a, 1'b1};
		@(negedge sys_clk) reg_rd = 1'b0;
		chk(reg_rdata_q, e, m);
	endtask
	task automatic wait_idle();
		for (int i = 0; i < 3000 && (rdrv || mdrv); i++) @(negedge sys_clk);
		chk({31'h0, rdrv | mdrv}, 32'h0, 32'h1);
	endtask
	task automatic tally_and_finish();
		if (num_errors == 0 && n_compared > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================
	// scenarios
	task automatic t_detached();
		rd(32'h0, 32'h1f);
		wr(32'h10, 8'h50);
		rd(32'h0, 32'hffffffff, 8'h50);
		wr(32'h16);
		rd(32'h10000, 32'h1001f);
		wr(32'h10000);
		oc = 1'b1;
		rd(32'h0, 32'h8);
		oc = 1'b0;
		nonrem = 1'b1;
		rd(32'h10001, 32'h10001);
		nonrem = 1'b0;
	endtask
	task automatic t_faults();
		attach = 1'b1;
		for (int k = 0; k < 4; k++) begin
			wr(32'h2);
			rd(32'h3, 32'h3);
			case (k)
				0: oc = 1'b1;
				1: pwr = 1'b1;
				2: berr = 1'b1;
				default: attach = 1'b0;
			endcase
			repeat (3) @(negedge sys_clk);
			if (k == 0) rd(32'h8, 32'h8);
			rd(32'h20000, 32'h20002);
			{oc, pwr, berr, attach} = 4'h1;
			wr(32'h1f0000);
		end
		wr(32'h2);
		wr(32'h1);
		rd(32'h0, 32'h2);
	endtask
	task automatic t_reset();
		wr(32'h4);
		wr(32'h0);
		rd(32'h4, 32'h16);
		wr(32'h10);
		rd(32'h14, 32'h14);
		wait_idle();
		rd(32'h100002, 32'h10001e);
		wr(32'h100000);
	endtask
	task automatic t_resume();
		wr(32'h8);
		repeat (2) @(negedge sys_clk);
		chk({31'h0, mdrv}, 32'h0, 32'h1);
		wr(32'h5);
		wake = 1'b1;
		repeat (3) @(negedge sys_clk);
		chk({31'h0, tohc}, 32'h1, 32'h1);
		wake = 1'b0;
		wr(32'h8);
		rd(32'h4, 32'h6);
		chk({31'h0, mdrv}, 32'h1, 32'h1);
		wait_idle();
		rd(32'h40002, 32'h40006);
		wr(32'h4);
		rd(32'h5, 32'h5);
		hcres = 1'b1;
		repeat (2) @(negedge sys_clk);
		rd(32'h0, 32'h4);
		hcres = 1'b0;
	endtask
	// ==========================================================
	// clock, reset, sequence and watchdog
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	initial begin
		{rst_n, reg_wr, reg_rd, nonrem, oc, ppo, pwr, berr, hcres, attach, wake} = '0;
		{reg_addr, reg_wdata} = '0;
		{num_errors, n_compared} = '0;
		repeat (10) @(negedge sys_clk);
		rst_n = 1'b1;
		t_detached();
		ppo = 1'b1;
		t_faults();
		t_reset();
		t_resume();
		tally_and_finish();
	end
	initial begin
		#200us;
		num_errors++;
		tally_and_finish();
	end
endmodule
